// *** hdl/irq_expand_defs.vh ***
`ifndef IRQ_EXPAND_DEFS_VH
`define IRQ_EXPAND_DEFS_VH

// Core vector locations
`define VEC_RESET        16'h0000
`define VEC_CORE_ONE     16'h0002
`define VEC_CORE_TWO     16'h0004
`define VEC_SOFT_NMI     16'h0024

// Request register bit positions, register 0
`define POS_PROT_A       0
`define POS_CONV_DONE    1
`define POS_EXT_A        2
`define POS_EXT_B        3
`define POS_SYNC_SER     4
`define POS_ASYNC_RX     5
`define POS_ASYNC_TX     6
`define POS_BUS_MBOX     7
`define POS_BUS_ERR      8
`define POS_CMP_1        9
`define POS_CMP_2        10
`define POS_CMP_3        11
`define POS_TA_PER       12
`define POS_TA_CMP       13
`define POS_TA_UND       14
`define POS_TA_OVF       15
// Register 2
`define POS_PROT_B       0
`define POS_CMP_4        1
`define POS_CMP_5        2
`define POS_CMP_6        3
`define POS_TC_PER       4
`define POS_TC_CMP       5
`define POS_TC_UND       6
`define POS_TC_OVF       7

// Source vector codes
`define SVC_NONE         16'h0000
`define SVC_PROT_A       16'h0020
`define SVC_PROT_B       16'h0019
`define SVC_CONV_DONE    16'h0004
`define SVC_EXT_A        16'h0001
`define SVC_EXT_B        16'h0011
`define SVC_SYNC_SER     16'h0005
`define SVC_ASYNC_RX     16'h0006
`define SVC_ASYNC_TX     16'h0007
`define SVC_BUS_MBOX     16'h0040
`define SVC_BUS_ERR      16'h0041
`define SVC_CMP_1        16'h0021
`define SVC_CMP_2        16'h0022
`define SVC_CMP_3        16'h0023
`define SVC_TA_PER       16'h0027
`define SVC_TA_CMP       16'h0028
`define SVC_TA_UND       16'h0029
`define SVC_TA_OVF       16'h002a
`define SVC_CMP_4        16'h0024
`define SVC_CMP_5        16'h0025
`define SVC_CMP_6        16'h0026
`define SVC_TC_PER       16'h002f
`define SVC_TC_CMP       16'h0030
`define SVC_TC_UND       16'h0031
`define SVC_TC_OVF       16'h0032

`define REQ_WIDTH        16
`define VEC_WIDTH        16

`endif

// *** hdl/pending_flag.v ***
`timescale 1ns/1ps
`default_nettype none

module pending_flag (
	// Clock and reset
	input  wire i_sys_clk,
	input  wire i_reset,
	// Event and clear
	input  wire i_set,
	input  wire i_clear,
	// State
	output reg  o_pending
);

	// Set wins over a clear in the same cycle
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_pending <= 1'b0;
		end else if (i_set) begin
			o_pending <= 1'b1;
		end else if (i_clear) begin
			o_pending <= 1'b0;
		end
	end

endmodule // pending_flag

`default_nettype wire

// *** hdl/irq_expand.v ***
`timescale 1ns/1ps
`default_nettype none
`include "irq_expand_defs.vh"

module irq_expand #(
	parameter HAS_SECOND_EVENT_MANAGER = 1,
	parameter HAS_BUS_CTRL             = 1,
	parameter HAS_SYNC_SERIAL          = 1,
	parameter HAS_ASYNC_SERIAL         = 1
) (
	// Clock and reset
	input  wire                     i_sys_clk,
	input  wire                     i_reset,
	// Reset sources
	input  wire                     i_reset_pin,
	input  wire                     i_watchdog_expired,
	// Software unmaskable trigger
	input  wire                     i_soft_nmi_instr,
	// Source requests, one-cycle pulses
	input  wire                     i_prot_a_req,
	input  wire                     i_prot_b_req,
	input  wire                     i_converter_done_req,
	input  wire                     i_ext_pin_req_a,
	input  wire                     i_ext_pin_req_b,
	input  wire                     i_sync_serial_req,
	input  wire                     i_async_receive_req,
	input  wire                     i_async_transmit_req,
	input  wire                     i_bus_mailbox_req,
	input  wire                     i_bus_error_req,
	input  wire [2:0]               i_compare_a_req,
	input  wire                     i_timer_a_period_req,
	input  wire                     i_timer_a_compare_req,
	input  wire                     i_timer_a_underflow_req,
	input  wire                     i_timer_a_overflow_req,
	input  wire [2:0]               i_compare_c_req,
	input  wire                     i_timer_c_period_req,
	input  wire                     i_timer_c_compare_req,
	input  wire                     i_timer_c_underflow_req,
	input  wire                     i_timer_c_overflow_req,
	// Priority mode, high when the shared sources use line one
	input  wire                     i_high_priority_mode,
	// Source enables and core masks
	input  wire [`REQ_WIDTH-1:0]    i_enable_reg0,
	input  wire [`REQ_WIDTH-1:0]    i_enable_reg2,
	input  wire                     i_core_mask_one,
	input  wire                     i_core_mask_two,
	// Core acknowledge of a line, one-cycle pulse
	input  wire                     i_core_ack_one,
	input  wire                     i_core_ack_two,
	// To the core
	output reg                      o_core_reset,
	output reg                      o_core_nmi,
	output reg                      o_core_line_one,
	output reg                      o_core_line_two,
	output reg  [`VEC_WIDTH-1:0]    o_core_vector,
	output reg  [`VEC_WIDTH-1:0]    o_source_vector_code_one,
	output reg  [`VEC_WIDTH-1:0]    o_source_vector_code_two,
	output reg  [`REQ_WIDTH-1:0]    o_pending_request_reg0,
	output reg  [`REQ_WIDTH-1:0]    o_pending_request_reg2
);

	////////////////////////////////////////////////////////////////////////
	// Source gating and pending flags

	wire hp = i_high_priority_mode;
	wire has_b = (HAS_SECOND_EVENT_MANAGER != 0);
	wire has_can = (HAS_BUS_CTRL != 0);
	wire has_spi = (HAS_SYNC_SERIAL != 0);
	wire has_sci = (HAS_ASYNC_SERIAL != 0);

	reg  [`REQ_WIDTH-1:0] set0;
	reg  [`REQ_WIDTH-1:0] set2;
	wire [`REQ_WIDTH-1:0] pend0;
	wire [`REQ_WIDTH-1:0] pend2;
	reg  [`REQ_WIDTH-1:0] next_ack0;
	reg  [`REQ_WIDTH-1:0] next_ack2;
	reg  [`REQ_WIDTH-1:0] request_acknowledge_reg0;
	reg  [`REQ_WIDTH-1:0] request_acknowledge_reg2;

	// Low-priority routes of shared sources live on other lines, not here
	always @* begin
		set0 = {`REQ_WIDTH{1'b0}};
		set2 = {`REQ_WIDTH{1'b0}};
		set0[`POS_PROT_A]    = i_prot_a_req;
		set0[`POS_CONV_DONE] = hp & i_converter_done_req;
		set0[`POS_EXT_A]     = hp & i_ext_pin_req_a;
		set0[`POS_EXT_B]     = hp & i_ext_pin_req_b;
		set0[`POS_SYNC_SER]  = hp & has_spi & i_sync_serial_req;
		set0[`POS_ASYNC_RX]  = hp & has_sci & i_async_receive_req;
		set0[`POS_ASYNC_TX]  = hp & has_sci & i_async_transmit_req;
		set0[`POS_BUS_MBOX]  = hp & has_can & i_bus_mailbox_req;
		set0[`POS_BUS_ERR]   = hp & has_can & i_bus_error_req;
		set0[`POS_CMP_1]     = i_compare_a_req[0];
		set0[`POS_CMP_2]     = i_compare_a_req[1];
		set0[`POS_CMP_3]     = i_compare_a_req[2];
		set0[`POS_TA_PER]    = i_timer_a_period_req;
		set0[`POS_TA_CMP]    = i_timer_a_compare_req;
		set0[`POS_TA_UND]    = i_timer_a_underflow_req;
		set0[`POS_TA_OVF]    = i_timer_a_overflow_req;
		set2[`POS_PROT_B]    = has_b & i_prot_b_req;
		set2[`POS_CMP_4]     = has_b & i_compare_c_req[0];
		set2[`POS_CMP_5]     = has_b & i_compare_c_req[1];
		set2[`POS_CMP_6]     = has_b & i_compare_c_req[2];
		set2[`POS_TC_PER]    = has_b & i_timer_c_period_req;
		set2[`POS_TC_CMP]    = has_b & i_timer_c_compare_req;
		set2[`POS_TC_UND]    = has_b & i_timer_c_underflow_req;
		set2[`POS_TC_OVF]    = has_b & i_timer_c_overflow_req;
	end

	genvar g;
	generate
		for (g = 0; g < `REQ_WIDTH; g = g + 1) begin : g_flag
			pending_flag u_flag0 (
				.i_sys_clk (i_sys_clk),
				.i_reset   (i_reset),
				.i_set     (set0[g]),
				.i_clear   (request_acknowledge_reg0[g]),
				.o_pending (pend0[g])
			);
			pending_flag u_flag2 (
				.i_sys_clk (i_sys_clk),
				.i_reset   (i_reset),
				.i_set     (set2[g]),
				.i_clear   (request_acknowledge_reg2[g]),
				.o_pending (pend2[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Priority resolve per core line

	wire [`REQ_WIDTH-1:0] live0 = pend0 & i_enable_reg0;
	wire [`REQ_WIDTH-1:0] live2 = pend2 & i_enable_reg2;

	// Line one carries 0.0..0.8 and 2.0; line two 0.9..0.15 and 2.1..2.7
	wire line1_any = (|live0[`POS_BUS_ERR:`POS_PROT_A]) | live2[`POS_PROT_B];
	wire line2_any = (|live0[`POS_TA_OVF:`POS_CMP_1]) | (|live2[`POS_TC_OVF:`POS_CMP_4]);

	reg [`VEC_WIDTH-1:0] next_code1;
	reg [`VEC_WIDTH-1:0] next_code2;

	// Fixed order follows the overall priority numbers
	always @* begin
		next_ack0 = {`REQ_WIDTH{1'b0}};
		next_ack2 = {`REQ_WIDTH{1'b0}};
		next_code1 = `SVC_NONE;
		if (live0[`POS_PROT_A]) begin
			next_code1 = `SVC_PROT_A;
			next_ack0[`POS_PROT_A] = i_core_ack_one;
		end else if (live2[`POS_PROT_B]) begin
			next_code1 = `SVC_PROT_B;
			next_ack2[`POS_PROT_B] = i_core_ack_one;
		end else if (live0[`POS_CONV_DONE]) begin
			next_code1 = `SVC_CONV_DONE;
			next_ack0[`POS_CONV_DONE] = i_core_ack_one;
		end else if (live0[`POS_EXT_A]) begin
			next_code1 = `SVC_EXT_A;
			next_ack0[`POS_EXT_A] = i_core_ack_one;
		end else if (live0[`POS_EXT_B]) begin
			next_code1 = `SVC_EXT_B;
			next_ack0[`POS_EXT_B] = i_core_ack_one;
		end else if (live0[`POS_SYNC_SER]) begin
			next_code1 = `SVC_SYNC_SER;
			next_ack0[`POS_SYNC_SER] = i_core_ack_one;
		end else if (live0[`POS_ASYNC_RX]) begin
			next_code1 = `SVC_ASYNC_RX;
			next_ack0[`POS_ASYNC_RX] = i_core_ack_one;
		end else if (live0[`POS_ASYNC_TX]) begin
			next_code1 = `SVC_ASYNC_TX;
			next_ack0[`POS_ASYNC_TX] = i_core_ack_one;
		end else if (live0[`POS_BUS_MBOX]) begin
			next_code1 = `SVC_BUS_MBOX;
			next_ack0[`POS_BUS_MBOX] = i_core_ack_one;
		end else if (live0[`POS_BUS_ERR]) begin
			next_code1 = `SVC_BUS_ERR;
			next_ack0[`POS_BUS_ERR] = i_core_ack_one;
		end
		next_code2 = `SVC_NONE;
		if (live0[`POS_CMP_1]) begin
			next_code2 = `SVC_CMP_1;
			next_ack0[`POS_CMP_1] = i_core_ack_two;
		end else if (live0[`POS_CMP_2]) begin
			next_code2 = `SVC_CMP_2;
			next_ack0[`POS_CMP_2] = i_core_ack_two;
		end else if (live0[`POS_CMP_3]) begin
			next_code2 = `SVC_CMP_3;
			next_ack0[`POS_CMP_3] = i_core_ack_two;
		end else if (live0[`POS_TA_PER]) begin
			next_code2 = `SVC_TA_PER;
			next_ack0[`POS_TA_PER] = i_core_ack_two;
		end else if (live0[`POS_TA_CMP]) begin
			next_code2 = `SVC_TA_CMP;
			next_ack0[`POS_TA_CMP] = i_core_ack_two;
		end else if (live0[`POS_TA_UND]) begin
			next_code2 = `SVC_TA_UND;
			next_ack0[`POS_TA_UND] = i_core_ack_two;
		end else if (live0[`POS_TA_OVF]) begin
			next_code2 = `SVC_TA_OVF;
			next_ack0[`POS_TA_OVF] = i_core_ack_two;
		end else if (live2[`POS_CMP_4]) begin
			next_code2 = `SVC_CMP_4;
			next_ack2[`POS_CMP_4] = i_core_ack_two;
		end else if (live2[`POS_CMP_5]) begin
			next_code2 = `SVC_CMP_5;
			next_ack2[`POS_CMP_5] = i_core_ack_two;
		end else if (live2[`POS_CMP_6]) begin
			next_code2 = `SVC_CMP_6;
			next_ack2[`POS_CMP_6] = i_core_ack_two;
		end else if (live2[`POS_TC_PER]) begin
			next_code2 = `SVC_TC_PER;
			next_ack2[`POS_TC_PER] = i_core_ack_two;
		end else if (live2[`POS_TC_CMP]) begin
			next_code2 = `SVC_TC_CMP;
			next_ack2[`POS_TC_CMP] = i_core_ack_two;
		end else if (live2[`POS_TC_UND]) begin
			next_code2 = `SVC_TC_UND;
			next_ack2[`POS_TC_UND] = i_core_ack_two;
		end else if (live2[`POS_TC_OVF]) begin
			next_code2 = `SVC_TC_OVF;
			next_ack2[`POS_TC_OVF] = i_core_ack_two;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core-facing registers

	reg [`VEC_WIDTH-1:0] next_vector;

	// Reset outranks the soft unmaskable, which outranks the lines
	always @* begin
		next_vector = `VEC_CORE_TWO;
		if (i_reset_pin | i_watchdog_expired) begin
			next_vector = `VEC_RESET;
		end else if (i_soft_nmi_instr) begin
			next_vector = `VEC_SOFT_NMI;
		end else if (line1_any & i_core_mask_one) begin
			next_vector = `VEC_CORE_ONE;
		end else if (line2_any & i_core_mask_two) begin
			next_vector = `VEC_CORE_TWO;
		end else begin
			next_vector = o_core_vector;
		end
	end

	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_core_reset             <= 1'b0;
			o_core_nmi               <= 1'b0;
			o_core_line_one          <= 1'b0;
			o_core_line_two          <= 1'b0;
			o_core_vector            <= `VEC_RESET;
			o_source_vector_code_one <= `SVC_NONE;
			o_source_vector_code_two <= `SVC_NONE;
			o_pending_request_reg0   <= {`REQ_WIDTH{1'b0}};
			o_pending_request_reg2   <= {`REQ_WIDTH{1'b0}};
			request_acknowledge_reg0 <= {`REQ_WIDTH{1'b0}};
			request_acknowledge_reg2 <= {`REQ_WIDTH{1'b0}};
		end else begin
			o_core_reset             <= i_reset_pin | i_watchdog_expired;
			// No hardware pin feeds this; only the instruction does
			o_core_nmi               <= i_soft_nmi_instr;
			o_core_line_one          <= line1_any & i_core_mask_one;
			o_core_line_two          <= line2_any & i_core_mask_two;
			o_core_vector            <= next_vector;
			o_source_vector_code_one <= next_code1;
			o_source_vector_code_two <= next_code2;
			o_pending_request_reg0   <= pend0;
			o_pending_request_reg2   <= pend2;
			request_acknowledge_reg0 <= next_ack0;
			request_acknowledge_reg2 <= next_ack2;
		end
	end

endmodule // irq_expand

`default_nettype wire

// *** dv/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Core side: acknowledges a raised line, then rests so the cleared flag is gone before it looks again
module core_model (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	// Lines from the block and pause length
	input  wire logic       i_line_one,
	input  wire logic       i_line_two,
	input  wire logic [3:0] i_delay,
	// Acknowledge pulses
	output var  logic       o_ack_one,
	output var  logic       o_ack_two
);
	logic [4:0] rest_one;
	logic [4:0] rest_two;
	////////////////////////////////////////////////////////////////////////////////
	// Four cycles is the shortest rest: a second ack after a rest of fewer than three would act on a stale line
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_ack_one <= 1'b0;
			o_ack_two <= 1'b0;
			rest_one  <= 5'h00;
			rest_two  <= 5'h00;
		end else begin
			o_ack_one <= i_line_one && rest_one == 5'h00;
			o_ack_two <= i_line_two && rest_two == 5'h00;
			rest_one  <= (i_line_one && rest_one == 5'h00) ? 5'h04 + i_delay : rest_one - (rest_one != 5'h00);
			rest_two  <= (i_line_two && rest_two == 5'h00) ? 5'h04 + i_delay : rest_two - (rest_two != 5'h00);
		end
	end
endmodule // core_model
`default_nettype wire

// *** dv/irq_expand_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_expand_checker (
	// Clock and reset
	input wire logic        i_sys_clk,
	input wire logic        i_reset,
	// Watched inputs
	input wire logic        i_reset_pin,
	input wire logic        i_watchdog_expired,
	input wire logic        i_soft_nmi_instr,
	input wire logic        i_converter_done_req,
	input wire logic        i_ext_pin_req_a,
	input wire logic        i_timer_a_period_req,
	input wire logic        i_high_priority_mode,
	input wire logic [15:0] i_enable_reg0,
	input wire logic        i_core_mask_one,
	input wire logic        i_core_mask_two,
	input wire logic        i_core_ack_two,
	// Watched outputs
	input wire logic        o_core_reset,
	input wire logic        o_core_nmi,
	input wire logic        o_core_line_one,
	input wire logic        o_core_line_two,
	input wire logic [15:0] o_core_vector,
	input wire logic [15:0] o_source_vector_code_one,
	input wire logic [15:0] o_source_vector_code_two,
	input wire logic [15:0] o_pending_request_reg0
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	////////////////////////////////////////////////////////////////////////////////
	reset_to_zero_a: assert property ((i_reset_pin || i_watchdog_expired) |=> o_core_reset && o_core_vector == 16'h0000)
		else $error("reset not taken to vector zero");
	reset_only_src_a: assert property (!(i_reset_pin || i_watchdog_expired) |=> !o_core_reset)
		else $error("reset raised without a source");
	soft_nmi_a: assert property (i_soft_nmi_instr && !i_reset_pin && !i_watchdog_expired |=> o_core_nmi && o_core_vector == 16'h0024)
		else $error("software unmaskable not taken");
	nmi_soft_only_a: assert property (!i_soft_nmi_instr |=> !o_core_nmi)
		else $error("unmaskable raised without instruction");
	conv_done_line_a: assert property (i_converter_done_req && i_high_priority_mode && i_enable_reg0[1] && i_core_mask_one
		|-> ##2 o_core_line_one && o_pending_request_reg0[1])
		else $error("converter done not on line one");
	line_one_vector_a: assert property ($rose(o_core_line_one) && !o_core_reset && !o_core_nmi |-> o_core_vector == 16'h0002)
		else $error("line one vector wrong");
	timer_period_a: assert property (i_timer_a_period_req && i_enable_reg0[12] && i_core_mask_two
		|-> ##2 o_core_line_two && o_pending_request_reg0[12])
		else $error("timer period not on line two");
	ack_clears_a: assert property (i_core_ack_two && o_source_vector_code_two == 16'h0027 ##1 !i_timer_a_period_req
		|=> ##1 !o_pending_request_reg0[12])
		else $error("ack did not clear flag");
	mode_gate_a: assert property ($rose(o_pending_request_reg0[2]) |-> $past(i_ext_pin_req_a, 2) && $past(i_high_priority_mode, 2))
		else $error("pin flag set without request in high mode");
	mask_one_a: assert property (!i_core_mask_one |=> !o_core_line_one)
		else $error("masked line one raised");
	////////////////////////////////////////////////////////////////////////////////
	cover property (o_source_vector_code_one == 16'h0041);
	cover property (i_core_ack_two && o_source_vector_code_two == 16'h0027);
	cover property (o_core_nmi);
endmodule // irq_expand_checker
bind irq_expand irq_expand_checker irq_expand_checker_inst (.i_sys_clk, .i_reset, .i_reset_pin, .i_watchdog_expired,
	.i_soft_nmi_instr, .i_converter_done_req, .i_ext_pin_req_a, .i_timer_a_period_req, .i_high_priority_mode,
	.i_enable_reg0, .i_core_mask_one, .i_core_mask_two, .i_core_ack_two, .o_core_reset, .o_core_nmi,
	.o_core_line_one, .o_core_line_two, .o_core_vector, .o_source_vector_code_one, .o_source_vector_code_two,
	.o_pending_request_reg0);
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	// Source index k: 0..15 are bits 0.k, 16..23 are bits 2.(k-16)
	localparam logic [15:0] CODES [24] = '{16'h0020, 16'h0004, 16'h0001, 16'h0011, 16'h0005, 16'h0006, 16'h0007,
		16'h0040, 16'h0041, 16'h0021, 16'h0022, 16'h0023, 16'h0027, 16'h0028, 16'h0029, 16'h002a,
		16'h0019, 16'h0024, 16'h0025, 16'h0026, 16'h002f, 16'h0030, 16'h0031, 16'h0032};
	localparam int ORD [24] = '{0, 16, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 17, 18, 19, 20, 21, 22, 23};
	logic        clk = 0, rst = 1, rpin = 0, wdog = 0, nmi = 0, mode = 1, m1 = 1, m2 = 1;
	logic [23:0] req = 0, en = '1, s;
	logic [3:0]  dly = 0;
	wire logic   a1, a2, l1, l2, cr, cn;
	wire logic [15:0] vec, c1, c2, p0, p2;
	wire logic [23:0] pend;
	int          failures = 0, total_checks = 0, seed = 32'hb61714ba, i, n, w;
	assign pend = {p2[7:0], p0};
	////////////////////////////////////////////////////////////////////////////////
	irq_expand irq_expand_inst (.i_sys_clk(clk), .i_reset(rst), .i_reset_pin(rpin), .i_watchdog_expired(wdog),
		.i_soft_nmi_instr(nmi), .i_prot_a_req(req[0]), .i_prot_b_req(req[16]), .i_converter_done_req(req[1]),
		.i_ext_pin_req_a(req[2]), .i_ext_pin_req_b(req[3]), .i_sync_serial_req(req[4]), .i_async_receive_req(req[5]),
		.i_async_transmit_req(req[6]), .i_bus_mailbox_req(req[7]), .i_bus_error_req(req[8]),
		.i_compare_a_req(req[11:9]), .i_timer_a_period_req(req[12]), .i_timer_a_compare_req(req[13]),
		.i_timer_a_underflow_req(req[14]), .i_timer_a_overflow_req(req[15]), .i_compare_c_req(req[19:17]),
		.i_timer_c_period_req(req[20]), .i_timer_c_compare_req(req[21]), .i_timer_c_underflow_req(req[22]),
		.i_timer_c_overflow_req(req[23]), .i_high_priority_mode(mode), .i_enable_reg0(en[15:0]),
		.i_enable_reg2({8'hff, en[23:16]}), .i_core_mask_one(m1), .i_core_mask_two(m2), .i_core_ack_one(a1),
		.i_core_ack_two(a2), .o_core_reset(cr), .o_core_nmi(cn), .o_core_line_one(l1), .o_core_line_two(l2),
		.o_core_vector(vec), .o_source_vector_code_one(c1), .o_source_vector_code_two(c2),
		.o_pending_request_reg0(p0), .o_pending_request_reg2(p2));
	core_model core_model_inst (.i_sys_clk(clk), .i_reset(rst), .i_line_one(l1), .i_line_two(l2), .i_delay(dly),
		.o_ack_one(a1), .o_ack_two(a2));
	initial begin
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] best(input int line, input logic [23:0] set);
		int k;
		for (int j = 0; j < 24; j++) begin
			k = ORD[j];
			if (set[k] && ((k <= 8 || k == 16) ? 1 : 2) == line) return CODES[k];
		end
		return 16'h0000;
	endfunction
	task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task results;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Inputs move 1 ns after the edge so the design never races the bench
	task cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task pulse(input logic [23:0] v);
		req = v;
		cyc(1);
		req = '0;
	endtask
	// Bounded wait for the core to drain both lines
	task settle;
		// Every source acked in turn with the longest rest needs about 280 cycles (14 line-two sources, 20 cycles each)
		for (w = 0; w < 1000 && (l1 || l2); w++) cyc(1);
		if (l1 || l2) begin
			failures++;
			$display("CHECK FAILED t=%0t lines never drained", $time);
			results();
		end
		cyc(3);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		#1 rst = 0;
		chk({vec, c1, l1, l2, cr, cn}, 0, "reset state");
		chk(pend, 0, "reset flags");
		for (i = 0; i < 24; i++) begin
			pulse(24'h1 << i);
			cyc(1);
			n = (i <= 8 || i == 16) ? 1 : 2;
			chk({l1, l2}, n == 1 ? 2 : 1, "line");
			chk(n == 1 ? c1 : c2, CODES[i], "code");
			chk(vec, n == 1 ? 16'h0002 : 16'h0004, "core vector");
			chk(pend[i], 1, "flag position");
			settle();
			chk(pend, 0, "ack cleared");
		end
		for (i = 0; i < 30; i++) begin
			s = 24'($random(seed));
			en = 24'($random(seed) | $random(seed));
			dly = 4'($random(seed));
			if (i == 0) s = 24'h000180;
			if (i < 2) en = '1;
			if (i == 1) s = '1;
			cyc(1);
			pulse(s);
			cyc(1);
			chk(c1, best(1, s & en), "rank one");
			chk(c2, best(2, s & en), "rank two");
			settle();
			chk(pend, s & ~en, "hidden stay");
			en = '1;
			cyc(3);
			settle();
		end
		for (i = 0; i < 2; i++) begin
			m1 = i;
			m2 = !i;
			pulse(i ? 24'h001000 : 24'h000004);
			cyc(4);
			chk({l1, l2}, 0, "masked");
			chk(pend, i ? 24'h001000 : 24'h000004, "masked flag");
			m1 = 1;
			m2 = 1;
			cyc(2);
			chk({l1, l2}, i ? 1 : 2, "unmasked");
			settle();
		end
		mode = 0;
		pulse(24'h0001fe);
		cyc(3);
		chk(pend, 0, "low mode");
		chk({l1, l2}, 0, "low mode line");
		mode = 1;
		pulse(24'h0001ff);
		cyc(1);
		chk(cn, 0, "no hardware unmaskable");
		settle();
		nmi = 1;
		cyc(1);
		chk({cn, vec}, {1'b1, 16'h0024}, "soft unmaskable");
		nmi = 0;
		cyc(2);
		for (i = 0; i < 2; i++) begin
			rpin = !i;
			wdog = i;
			cyc(1);
			chk({cr, vec}, {1'b1, 16'h0000}, "reset source");
			rpin = 0;
			wdog = 0;
			cyc(2);
			chk(cr, 0, "reset gone");
		end
		results();
	end
endmodule // tb
`default_nettype wire
